// >>> rtl/tpc_pin_ctrl.sv
// pin function control for channel 4 D and channel 0 A/C general registers
`timescale 1ns/100ps
module tpc_pin_ctrl
(
   input wire logic clk,
   input wire logic rst_n,
   input wire tpc_pkg::tpc_bus_req_t bus_req,
   output logic [7:0] rd_data,
   input wire logic [15:0] cnt_ch4,
   input wire logic cnt_tick_ch4,
   input wire logic [15:0] cnt_ch0,
   input wire logic cnt_tick_ch0,
   input wire logic ch1_count_evt,
   input wire logic standby,
   input wire logic timer_pin_b_ch4_in,
   input wire logic timer_pin_a_ch0_in,
   input wire logic timer_pin_c_ch0_in,
   output tpc_pkg::tpc_pin_t timer_pin_b_ch4,
   output tpc_pkg::tpc_pin_t timer_pin_a_ch0,
   output tpc_pkg::tpc_pin_t timer_pin_c_ch0,
   output logic [2:0] capture_evt,
   output logic [2:0] compare_evt
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   // channel index: 0 = ch4 D, 1 = ch0 A, 2 = ch0 C
   localparam logic [2:0] CASC_OK = 3'b110;

   logic [7:0] ctrl_low_ch4_reg;
   logic [7:0] ctrl_high_ch0_reg;
   logic [7:0] ctrl_low_ch0_reg;
   logic [7:0] mode_ch4_reg;
   logic [7:0] mode_ch0_reg;
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;
   logic [2:0] pin_out_reg;
   logic [2:0] pin_out_next;
   logic [2:0] pin_oe_n_reg;
   logic [2:0] pin_oe_n_next;
   logic [2:0] cap_evt_reg;
   logic [2:0] cmp_evt_reg;

   logic [2:0] pin_raw;
   logic [2:0] pin_level;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;
   logic [2:0] buf_mode;
   logic [2:0] ctrl_we;
   logic [2:0] cap_hit;
   logic [2:0] cmp_hit;
   logic [2:0] gr_match;
   logic [2:0] cnt_tick;
   logic [3:0] field [3];
   logic [3:0] field_new [3];
   logic [15:0] cnt [3];
   logic [15:0] gr_val [3];
   logic [5:0] gr_we;
   logic [7:0] gr_rd;
   logic wr_stb;
   logic rd_stb;
   logic [3:0] addr;
   logic addr_gr;
   logic [1:0] gr_idx;
   logic [1:0] mode_we;
   logic [5:0] rd_sel;

   // ----------------------------------------
   // offset decode
   // ----------------------------------------
   // one strobe aimed at one register offset
   function automatic logic at_offset(input logic stb, input logic [3:0] a, input logic [3:0] off);
      return stb && (a == off);
   endfunction : at_offset

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign wr_stb = bus_req.wr;
   assign rd_stb = bus_req.rd;
   assign addr = bus_req.addr;
   // three register pairs follow the general register base
   assign addr_gr = (addr >= tpc_pkg::TPC_OFF_GR_BASE) &&
                    (addr < tpc_pkg::TPC_OFF_GR_BASE + 4'h6);
   assign gr_idx = 2'((addr - tpc_pkg::TPC_OFF_GR_BASE) >> 1);

   assign ctrl_we[0] = at_offset(wr_stb, addr, tpc_pkg::TPC_OFF_CTRL_LOW_CH4);
   assign ctrl_we[1] = at_offset(wr_stb, addr, tpc_pkg::TPC_OFF_CTRL_HIGH_CH0);
   assign ctrl_we[2] = at_offset(wr_stb, addr, tpc_pkg::TPC_OFF_CTRL_LOW_CH0);
   assign mode_we[0] = at_offset(wr_stb, addr, tpc_pkg::TPC_OFF_MODE_CH4);
   assign mode_we[1] = at_offset(wr_stb, addr, tpc_pkg::TPC_OFF_MODE_CH0);

   // read selects for the byte registers outside the general registers
   assign rd_sel[0] = at_offset(rd_stb, addr, tpc_pkg::TPC_OFF_CTRL_LOW_CH4);
   assign rd_sel[1] = at_offset(rd_stb, addr, tpc_pkg::TPC_OFF_CTRL_HIGH_CH0);
   assign rd_sel[2] = at_offset(rd_stb, addr, tpc_pkg::TPC_OFF_CTRL_LOW_CH0);
   assign rd_sel[3] = at_offset(rd_stb, addr, tpc_pkg::TPC_OFF_MODE_CH4);
   assign rd_sel[4] = at_offset(rd_stb, addr, tpc_pkg::TPC_OFF_MODE_CH0);
   assign rd_sel[5] = at_offset(rd_stb, addr, tpc_pkg::TPC_OFF_PIN_STAT);

   // byte write enables, low then high per general register
   genvar g;
   generate
      for (g = 0; g < 6; g++)
      begin : g_gr_we
         assign gr_we[g] = at_offset(wr_stb, addr, tpc_pkg::TPC_OFF_GR_BASE + 4'(g));
      end
   endgenerate

   // ----------------------------------------
   // field extraction
   // ----------------------------------------
   // field placement
   assign field[0] = ctrl_low_ch4_reg[tpc_pkg::TPC_D_FIELD_LSB +: 4];
   assign field[1] = ctrl_high_ch0_reg[tpc_pkg::TPC_AC_FIELD_LSB +: 4];
   assign field[2] = ctrl_low_ch0_reg[tpc_pkg::TPC_AC_FIELD_LSB +: 4];
   assign field_new[0] = bus_req.wdata[tpc_pkg::TPC_D_FIELD_LSB +: 4];
   assign field_new[1] = bus_req.wdata[tpc_pkg::TPC_AC_FIELD_LSB +: 4];
   assign field_new[2] = bus_req.wdata[tpc_pkg::TPC_AC_FIELD_LSB +: 4];

   assign buf_mode[0] = mode_ch4_reg[tpc_pkg::TPC_BFB_BIT];
   assign buf_mode[1] = 1'b0;
   assign buf_mode[2] = mode_ch0_reg[tpc_pkg::TPC_BFA_BIT];

   assign cnt[0] = cnt_ch4;
   assign cnt[1] = cnt_ch0;
   assign cnt[2] = cnt_ch0;
   // the channel 0 counter feeds both the A and C registers
   assign cnt_tick = {cnt_tick_ch0, cnt_tick_ch0, cnt_tick_ch4};
   assign pin_raw = {timer_pin_c_ch0_in, timer_pin_a_ch0_in, timer_pin_b_ch4_in};

   // ----------------------------------------
   // per-channel capture / compare
   // ----------------------------------------
   generate
      for (g = 0; g < 3; g++)
      begin : g_ch
         tpc_pkg::tpc_func_t fn;
         tpc_pkg::tpc_func_t fn_new;
         logic active;
         logic load_init;
         logic [3:0] fsel;

         // each pin passes two flops before its edges are read
         tpc_pin_sync u_sync
         (
            .clk(clk),
            .rst_n(rst_n),
            .pin_in(pin_raw[g]),
            .level(pin_level[g]),
            .rise(pin_rise[g]),
            .fall(pin_fall[g])
         );

         // no cascade option on the D field
         assign fn = tpc_pkg::tpc_decode(field[g], CASC_OK[g]);
         assign fn_new = tpc_pkg::tpc_decode(field_new[g], CASC_OK[g]);
         assign active = ~buf_mode[g] & ~standby;

         assign cap_hit[g] = active &
                             ((fn.cap_rise & pin_rise[g]) |
                              (fn.cap_fall & pin_fall[g]) |
                              (fn.cap_casc & ch1_count_evt));

         assign cmp_hit[g] = active & fn.is_out & cnt_tick[g] & gr_match[g];

         tpc_gen_reg u_gr
         (
            .clk(clk),
            .rst_n(rst_n),
            .wr_lo(gr_we[2 * g]),
            .wr_hi(gr_we[2 * g + 1]),
            .wdata(bus_req.wdata),
            .capture(cap_hit[g]),
            .count(cnt[g]),
            .value(gr_val[g]),
            .match(gr_match[g])
         );

         // a field write with a non-hold compare code outranks a same-cycle compare so the new level is kept
         // initial level on field write
         assign load_init = ctrl_we[g] & ~buf_mode[g] & fn_new.is_out &
                            (fn_new.act != tpc_pkg::TPC_ACT_HOLD);

         // standby forces low; hold codes leave the level alone
         always_comb
         begin
            pin_out_next[g] = pin_out_reg[g];
            if (standby)
               pin_out_next[g] = tpc_pkg::TPC_PIN_RST;
            else if (load_init)
               pin_out_next[g] = fn_new.init;
            else if (cmp_hit[g])
            begin
               unique case (fn.act)
                  tpc_pkg::TPC_ACT_LOW: pin_out_next[g] = 1'b0;
                  tpc_pkg::TPC_ACT_HIGH: pin_out_next[g] = 1'b1;
                  tpc_pkg::TPC_ACT_TOGGLE: pin_out_next[g] = ~pin_out_reg[g];
                  tpc_pkg::TPC_ACT_HOLD: pin_out_next[g] = pin_out_reg[g];
               endcase
            end
         end

         // pin is driven in compare mode, released in capture mode
         assign fsel = ctrl_we[g] ? field_new[g] : field[g];
         assign pin_oe_n_next[g] = standby ? 1'b0 : fsel[3];
      end
   endgenerate

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   // offsets past the third register pair are masked by addr_gr below
   assign gr_rd = addr[0] ? gr_val[gr_idx][15:8] : gr_val[gr_idx][7:0];

   // cycles without a read return zero so a reply stands one cycle only
   assign rd_data_next = !rd_stb ? 8'h00 :
      rd_sel[0] ? ctrl_low_ch4_reg :
      rd_sel[1] ? ctrl_high_ch0_reg :
      rd_sel[2] ? ctrl_low_ch0_reg :
      rd_sel[3] ? mode_ch4_reg :
      rd_sel[4] ? mode_ch0_reg :
      rd_sel[5] ? {2'h0, pin_level, pin_out_reg} :
      addr_gr ? gr_rd : 8'h00;

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_low_ch4_reg <= tpc_pkg::TPC_CTRL_RST;
         ctrl_high_ch0_reg <= tpc_pkg::TPC_CTRL_RST;
         ctrl_low_ch0_reg <= tpc_pkg::TPC_CTRL_RST;
      end
      else
      begin
         if (ctrl_we[0])
            ctrl_low_ch4_reg <= bus_req.wdata;
         if (ctrl_we[1])
            ctrl_high_ch0_reg <= bus_req.wdata;
         if (ctrl_we[2])
            ctrl_low_ch0_reg <= bus_req.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_ch4_reg <= tpc_pkg::TPC_MODE_RST;
         mode_ch0_reg <= tpc_pkg::TPC_MODE_RST;
      end
      else
      begin
         if (mode_we[0])
            mode_ch4_reg <= bus_req.wdata;
         if (mode_we[1])
            mode_ch0_reg <= bus_req.wdata;
      end
   end

   // ----------------------------------------
   // pins, events, read data
   // ----------------------------------------
   // pins low and driven from reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_out_reg <= {3{tpc_pkg::TPC_PIN_RST}};
         pin_oe_n_reg <= 3'h0;
         cap_evt_reg <= 3'h0;
         cmp_evt_reg <= 3'h0;
         rd_data_reg <= 8'h00;
      end
      else
      begin
         pin_out_reg <= pin_out_next;
         pin_oe_n_reg <= pin_oe_n_next;
         cap_evt_reg <= cap_hit;
         cmp_evt_reg <= cmp_hit;
         rd_data_reg <= rd_data_next;
      end
   end

   // events leave flip-flops in the same cycle as the store or pin update
   assign rd_data = rd_data_reg;
   assign capture_evt = cap_evt_reg;
   assign compare_evt = cmp_evt_reg;
   assign timer_pin_b_ch4 = '{out: pin_out_reg[0], oe_n: pin_oe_n_reg[0]};
   assign timer_pin_a_ch0 = '{out: pin_out_reg[1], oe_n: pin_oe_n_reg[1]};
   assign timer_pin_c_ch0 = '{out: pin_out_reg[2], oe_n: pin_oe_n_reg[2]};

endmodule : tpc_pin_ctrl

// >>> rtl/tpc_pkg.sv
// constants, types and field decoding for the timer pin i/o control block
// Functional notes
// - codes 0000 and 0100 hold the pin level; pin low after reset/standby until written
// - 0001 compare, initial 0, drive 0 at match; 0101 same with initial 1
// - 0010 initial 0, drive 1 at match; 0110 initial 1, drive 1 at match
// - 0011 initial 0, toggle at each match; 0111 same from initial 1
// - top bit 1, low bits 00: capture on pin rising edge
// - top bit 1, low bits 01: capture on pin falling edge
// - top bit 1, bit one 1: capture on both pin edges
// - channel 0 A and C, code 11xx: capture on channel 1 counter count
// - channel 4 D used as buffer: no capture or compare, no initial level; top bit still sets pin enable
package tpc_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int unsigned TPC_AW = 4;
   localparam int unsigned TPC_DW = 8;
   localparam int unsigned TPC_CW = 16;
   localparam int unsigned TPC_NCH = 3;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [3:0] TPC_OFF_CTRL_LOW_CH4 = 4'h0;
   localparam logic [3:0] TPC_OFF_CTRL_HIGH_CH0 = 4'h1;
   localparam logic [3:0] TPC_OFF_CTRL_LOW_CH0 = 4'h2;
   localparam logic [3:0] TPC_OFF_MODE_CH4 = 4'h3;
   localparam logic [3:0] TPC_OFF_MODE_CH0 = 4'h4;
   localparam logic [3:0] TPC_OFF_PIN_STAT = 4'h5;
   localparam logic [3:0] TPC_OFF_GR_BASE = 4'h8;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int unsigned TPC_D_FIELD_LSB = 4;
   localparam int unsigned TPC_AC_FIELD_LSB = 0;
   localparam int unsigned TPC_BFB_BIT = 1;
   localparam int unsigned TPC_BFA_BIT = 0;
   localparam logic [7:0] TPC_CTRL_RST = 8'h00;
   localparam logic [7:0] TPC_MODE_RST = 8'h00;
   localparam logic [15:0] TPC_GR_RST = 16'hffff;
   localparam logic TPC_PIN_RST = 1'b0;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      TPC_ACT_HOLD,
      TPC_ACT_LOW,
      TPC_ACT_HIGH,
      TPC_ACT_TOGGLE
   } tpc_act_t;

   typedef struct packed {
      logic is_out;
      logic init;
      tpc_act_t act;
      logic cap_rise;
      logic cap_fall;
      logic cap_casc;
   } tpc_func_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tpc_bus_req_t;

   typedef struct packed {
      logic out;
      logic oe_n;
   } tpc_pin_t;

   // ----------------------------------------
   // field decoding
   // ----------------------------------------
   function automatic tpc_func_t tpc_decode(input logic [3:0] f, input logic casc_ok);
      tpc_func_t r;
      r.is_out = ~f[3];
      r.init = f[2];
      r.act = tpc_act_t'(f[1:0]);
      r.cap_casc = f[3] & f[2] & casc_ok;
      r.cap_rise = f[3] & ~r.cap_casc & (f[1] | ~f[0]);
      r.cap_fall = f[3] & ~r.cap_casc & (f[1] | f[0]);
      return r;
   endfunction : tpc_decode

endpackage : tpc_pkg

// >>> rtl/tpc_pin_sync.sv
// two-stage synchroniser and edge detector for one timer pin
`timescale 1ns/100ps
module tpc_pin_sync
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic level,
   output logic rise,
   output logic fall
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign level = sync_reg;
   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;

endmodule : tpc_pin_sync

// >>> rtl/tpc_gen_reg.sv
// general register: software bytes, counter capture, compare equality
`timescale 1ns/100ps
module tpc_gen_reg
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [7:0] wdata,
   input wire logic capture,
   input wire logic [15:0] count,
   output logic [15:0] value,
   output logic match
);

   logic [15:0] gr_reg;
   logic [15:0] gr_next;

   // capture wins over a software write in the same cycle
   assign gr_next = capture ? count :
                    wr_hi ? {wdata, gr_reg[7:0]} :
                    wr_lo ? {gr_reg[15:8], wdata} : gr_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         gr_reg <= tpc_pkg::TPC_GR_RST;
      else
         gr_reg <= gr_next;
   end

   assign value = gr_reg;
   assign match = (gr_reg == count);

endmodule : tpc_gen_reg

// >>> verif/tpc_pin_ctrl_monitor.sv
// port checker for the timer pin control block
`timescale 1ns/100ps
module tpc_pin_ctrl_monitor
(
   input wire logic clk,
   input wire logic rst_n,
   input wire tpc_pkg::tpc_bus_req_t bus_req,
   input wire logic [7:0] rd_data,
   input wire logic cnt_tick_ch4,
   input wire logic ch1_count_evt,
   input wire logic standby,
   input wire tpc_pkg::tpc_pin_t timer_pin_b_ch4,
   input wire tpc_pkg::tpc_pin_t timer_pin_a_ch0,
   input wire tpc_pkg::tpc_pin_t timer_pin_c_ch0,
   input wire logic [2:0] capture_evt,
   input wire logic [2:0] compare_evt
);
   logic [7:0] ctl_reg [4];
   logic out_wr;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // --
   // shadow of control registers and the channel 4 mode register
   // --
   assign out_wr = bus_req.wr && bus_req.addr == 4'h0 && !standby && !bus_req.wdata[7];
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ctl_reg <= '{default: 8'h00};
      else if (bus_req.wr && bus_req.addr < 4'h4)
         ctl_reg[bus_req.addr[1:0]] <= bus_req.wdata;
   end

   // --
   // checks
   // --
   rd_idle_a: assert property (!bus_req.rd |=> rd_data == 8'h00)
      else $error("read data not zero outside read reply");
   rd_back_a: assert property (bus_req.rd && bus_req.addr < 4'h4 |=>
      rd_data == ctl_reg[$past(bus_req.addr[1:0])]) else $error("control read back wrong");
   standby_low_a: assert property (standby |=> {timer_pin_b_ch4, timer_pin_a_ch0, timer_pin_c_ch0} == 6'h00)
      else $error("pins not driven low in standby");
   hold_level_a: assert property (out_wr && bus_req.wdata[5:4] == 2'b00 && !cnt_tick_ch4 |=>
      $stable(timer_pin_b_ch4.out)) else $error("hold code changed pin");
   init_level_a: assert property (out_wr && bus_req.wdata[5:4] != 2'b00 && !ctl_reg[3][1] |=>
      timer_pin_b_ch4.out == $past(bus_req.wdata[6])) else $error("initial level wrong");
   oe_field_a: assert property (bus_req.wr && bus_req.addr == 4'h0 && !standby |=>
      timer_pin_b_ch4.oe_n == $past(bus_req.wdata[7])) else $error("pin enable does not follow mode");
   buffer_quiet_a: assert property (ctl_reg[3][1] |=> !compare_evt[0] && !capture_evt[0])
      else $error("event while buffered");
   toggle_pin_a: assert property (compare_evt[0] && $past(ctl_reg[0][5:4]) == 2'b11 &&
      !$past(bus_req.wr && bus_req.addr == 4'h0) |-> timer_pin_b_ch4.out != $past(timer_pin_b_ch4.out))
      else $error("toggle did not invert pin");
   cascade_cap_a: assert property (ctl_reg[1][3:2] == 2'b11 && ch1_count_evt && !standby |->
      ##[1:2] capture_evt[1]) else $error("cascade capture missing");
endmodule : tpc_pin_ctrl_monitor

bind tpc_pin_ctrl tpc_pin_ctrl_monitor mon (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
   .cnt_tick_ch4(cnt_tick_ch4), .ch1_count_evt(ch1_count_evt), .standby(standby),
   .timer_pin_b_ch4(timer_pin_b_ch4), .timer_pin_a_ch0(timer_pin_a_ch0), .timer_pin_c_ch0(timer_pin_c_ch0),
   .capture_evt(capture_evt), .compare_evt(compare_evt));

// >>> verif/tpc_pin_model.sv
// far-side model of the three timer pins
`timescale 1ns/100ps
module tpc_pin_model
(
   input wire tpc_pkg::tpc_pin_t pin_b,
   input wire tpc_pkg::tpc_pin_t pin_a,
   input wire tpc_pkg::tpc_pin_t pin_c,
   input wire logic [2:0] ext_lvl,
   output logic b_in,
   output logic a_in,
   output logic c_in
);
   // the block owns the wire while its enable is low, else the far side drives
   assign b_in = pin_b.oe_n ? ext_lvl[0] : pin_b.out;
   assign a_in = pin_a.oe_n ? ext_lvl[1] : pin_a.out;
   assign c_in = pin_c.oe_n ? ext_lvl[2] : pin_c.out;
endmodule : tpc_pin_model

// >>> verif/tpc_pin_ctrl_tb.sv
// self-checking bench for the timer pin control block
`timescale 1ns/100ps
module tpc_pin_ctrl_tb;
   logic clk;
   logic rst_n;
   tpc_pkg::tpc_bus_req_t bus_req;
   logic [7:0] rd_data;
   logic [15:0] cnt_ch4;
   logic [15:0] cnt_ch0;
   logic cnt_tick_ch4;
   logic cnt_tick_ch0;
   logic [2:0] cap_evt;
   logic [2:0] cmp_evt;
   logic [2:0] cap_seen = 3'h0;
   logic [2:0] cmp_seen = 3'h0;
   logic ch1_count_evt;
   logic standby;
   logic [2:0] ext_lvl;
   logic b_in;
   logic a_in;
   logic c_in;
   tpc_pkg::tpc_pin_t pin_b;
   tpc_pkg::tpc_pin_t pin_a;
   tpc_pkg::tpc_pin_t pin_c;
   logic [7:0] exp_q [$];
   logic rd_pend = 1'b0;
   int mismatches = 0;
   int check_count = 0;
   logic [31:0] seed;
   logic [15:0] v;
   logic [3:0] c;
   logic lvl;
   logic [7:0] g;
   logic [3:0] ini_list [8] = '{4'h5, 4'h0, 4'h1, 4'h6, 4'h4, 4'h2, 4'h7, 4'h3};
   logic [3:0] cmp_list [6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
   logic [3:0] cap_list [4] = '{4'h8, 4'h9, 4'ha, 4'hd};

   tpc_pin_ctrl uut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data), .cnt_ch4(cnt_ch4),
      .cnt_tick_ch4(cnt_tick_ch4), .cnt_ch0(cnt_ch0), .cnt_tick_ch0(cnt_tick_ch0), .ch1_count_evt(ch1_count_evt),
      .standby(standby), .timer_pin_b_ch4_in(b_in), .timer_pin_a_ch0_in(a_in), .timer_pin_c_ch0_in(c_in),
      .timer_pin_b_ch4(pin_b), .timer_pin_a_ch0(pin_a), .timer_pin_c_ch0(pin_c), .capture_evt(cap_evt),
      .compare_evt(cmp_evt));
   tpc_pin_model partner (.pin_b(pin_b), .pin_a(pin_a), .pin_c(pin_c), .ext_lvl(ext_lvl), .b_in(b_in),
      .a_in(a_in), .c_in(c_in));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // --
   // helpers
   // --
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   task automatic op(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
      @(posedge clk);
      bus_req <= '{a, d, w, r};
      cnt_tick_ch4 <= 1'b0;
      cnt_tick_ch0 <= 1'b0;
      ch1_count_evt <= 1'b0;
   endtask : op

   task automatic ev(input logic [15:0] n, input logic t, input logic e);
      @(posedge clk);
      bus_req.wr <= 1'b0;
      bus_req.rd <= 1'b0;
      cnt_ch4 <= n;
      cnt_ch0 <= n;
      cnt_tick_ch4 <= t;
      ch1_count_evt <= e;
   endtask : ev

   task automatic nop(input int n);
      repeat (n) op(4'h0, 8'h00, 1'b0, 1'b0);
   endtask : nop

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      op(a, 8'h00, 1'b0, 1'b1);
   endtask : rd

   task automatic do_reset();
      nop(2);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
   endtask : do_reset

   // reply watcher: the oldest noted value is due in the cycle after each read
   always @(posedge clk)
   begin
      if (rd_pend)
         check("rd_data", rd_data, exp_q.pop_front());
      rd_pend <= bus_req.rd && rst_n;
      cap_seen <= cap_seen | cap_evt;
      cmp_seen <= cmp_seen | cmp_evt;
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      mismatches++;
      complete_run();
   end

   // --
   // scenarios
   // --
   initial
   begin
      bus_req = '0;
      cnt_ch4 = 16'h0000;
      cnt_ch0 = 16'h0000;
      cnt_tick_ch4 = 1'b0;
      cnt_tick_ch0 = 1'b0;
      ch1_count_evt = 1'b0;
      standby = 1'b0;
      ext_lvl = 3'h0;
      rst_n = 1'b0;
      seed = 32'ha78e5de3;
      do_reset();
      for (int a = 0; a < 10; a++)
         rd(a[3:0], a > 7 ? 8'hff : 8'h00);
      for (int a = 0; a < 4; a++)
      begin
         v = 16'(xs());
         wr_rd(a[3:0]);
      end
      do_reset();
      lvl = 1'b0;
      foreach (ini_list[i])
      begin
         c = ini_list[i];
         if (c[1:0] != 2'b00)
            lvl = c[2];
         op(4'h0, {c, 4'h0}, 1'b1, 1'b0);
         nop(4);
         rd(4'h5, lvl ? 8'h09 : 8'h00);
      end
      foreach (cmp_list[i])
      begin
         c = cmp_list[i];
         v = 16'(xs());
         op(4'h8, v[7:0], 1'b1, 1'b0);
         op(4'h9, v[15:8], 1'b1, 1'b0);
         op(4'h0, {c, 4'h0}, 1'b1, 1'b0);
         ev(v + 16'h0001, 1'b1, 1'b0);
         ev(v, 1'b1, 1'b0);
         nop(4);
         lvl = c[1] ? (c[0] ? ~c[2] : 1'b1) : 1'b0;
         rd(4'h5, lvl ? 8'h09 : 8'h00);
      end
      op(4'h3, 8'h02, 1'b1, 1'b0);
      op(4'h0, 8'h60, 1'b1, 1'b0);
      ev(v, 1'b1, 1'b0);
      nop(4);
      rd(4'h5, 8'h00);
      op(4'h3, 8'h00, 1'b1, 1'b0);
      g = v[7:0];
      foreach (cap_list[i])
      begin
         c = cap_list[i];
         op(4'h0, {c, 4'h0}, 1'b1, 1'b0);
         for (int e = 1; e >= 0; e--)
         begin
            v = 16'(xs());
            ev(v, 1'b0, 1'b0);
            ext_lvl[0] <= e[0];
            nop(6);
            if (c[1] | (c[0] ^ e[0]))
               g = v[7:0];
            rd(4'h8, g);
         end
      end
      for (int k = 12; k < 16; k++)
      begin
         op(4'h1, 8'(k), 1'b1, 1'b0);
         v = 16'(xs());
         ev(v, 1'b0, 1'b1);
         nop(3);
         rd(4'ha, v[7:0]);
      end
      v = 16'(xs()) & 16'h7fff;
      op(4'ha, v[7:0], 1'b1, 1'b0);
      op(4'hb, v[15:8], 1'b1, 1'b0);
      op(4'h1, 8'h02, 1'b1, 1'b0);
      ev(v, 1'b0, 1'b0);
      cnt_tick_ch0 <= 1'b1;
      nop(4);
      rd(4'h5, 8'h12);
      op(4'h0, 8'h60, 1'b1, 1'b0);
      nop(4);
      standby <= 1'b1;
      nop(4);
      rd(4'h5, 8'h00);
      standby <= 1'b0;
      nop(3);
      check("event_seen", {2'h0, cap_seen, cmp_seen}, 8'h1b);
      complete_run();
   end

   task automatic wr_rd(input logic [3:0] a);
      op(a, v[7:0], 1'b1, 1'b0);
      rd(a, v[7:0]);
   endtask : wr_rd
endmodule : tpc_pin_ctrl_tb
